//--- hw/wdrs_pkg.sv
package wdrs_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned WD_MIN_FREQ_HZ = 5;
    localparam int unsigned WD_TIMEOUT_CYC = CLK_HZ / WD_MIN_FREQ_HZ;
    localparam int unsigned EXT_RST_MS = 2;
    localparam int unsigned EXT_RST_CYC = (CLK_HZ / 1000) * EXT_RST_MS;
    localparam int unsigned EXT_RST_SYNC_CYC = 2;

    // ------------------------------------------------------------
    // Watchdog I/O addresses
    // ------------------------------------------------------------
    localparam logic [8:0] WD_ADDR_LO = 9'h0FF;
    localparam logic [8:0] WD_ADDR_HI = 9'h1FF;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [7:0] REG_TIMER = 8'h10;

    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_WDEN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    localparam int IRQ_TIMEOUT_BIT = 0;
    localparam int IRQ_EXTRST_BIT = 1;
    localparam int IRQ_LOWV_BIT = 2;
    localparam int IRQ_CLEAR_BIT = 3;
    localparam int IRQ_W = 4;

    typedef enum logic [1:0] {
        WDRS_RUN,
        WDRS_HALT,
        WDRS_STOP,
        WDRS_RESET
    } wdrs_mode_e;

    typedef struct packed {
        logic clearOutputs;
        logic clearTimers;
        logic zeroIp;
        logic clearElements;
    } wdrs_ctl_s;

endpackage : wdrs_pkg

//--- hw/wdrs_supervisor.sv
// Operation
// - Relay energised only while watchdog address toggles at or above minimum rate.
// - Missing toggle times out, opens relay and darkens yellow indicator.
// - Any mode other than RUN clears the watchdog counter and drops relay.
// - Grounded external reset puts controller into reset within 2 ms.
// - External reset clears all digital outputs regardless of outputs-low jumper.
// - External reset clears timers and volatile flags.
// - External reset loads instruction pointer with zero for cold start.
// - Reset indicator lit while controller held in reset.
// - Low supply voltage forces the controller into reset.
// - Halt and Clear switches only act when switch-enable jumper fitted.
// - Outputs-low jumper forces outputs low in Halt or Stop.
// - Clear resets elements except registers and real-time clock.
// - Halt switch puts controller into Halt without programming unit.
//
// The APB slave port and the register offsets were chosen for this implementation.
module wdrs_supervisor
    import wdrs_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = WD_TIMEOUT_CYC,
    parameter int unsigned EXTRST_CYC = EXT_RST_CYC
)
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ioWrite,
    input wire logic [8:0] ioAddr,
    input wire logic ioData,
    input wire logic extReset_n,
    input wire logic supplyLow,
    input wire logic haltSwitch,
    input wire logic clearSwitch,
    input wire logic switch_enable_jumper,
    input wire logic outputs_low_jumper,
    output logic supervision_relay,
    output logic watchdogLed,
    output logic resetLed,
    output logic outputsForceLow,
    output wdrs_ctl_s ctlPulse,
    output wdrs_mode_e mode,
    output logic irq
);

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [1:0] ctrl;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic [IRQ_W-1:0] irqEvent;
    logic [31:0] wdCount;
    logic wdExpired;
    logic inReset;
    logic busWrite;
    logic addrOk;

    assign pready = 1'b1;
    assign busWrite = psel && penable && pwrite;
    assign addrOk = (paddr == REG_CTRL) || (paddr == REG_STATUS) || (paddr == REG_IRQ_STAT)
        || (paddr == REG_IRQ_MASK) || (paddr == REG_TIMER);
    assign pslverr = psel && penable && !addrOk;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            ctrl <= CTRL_RESET;
        else if (busWrite && paddr == REG_CTRL)
            ctrl <= pwdata[1:0];
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            irqMask <= '0;
        else if (busWrite && paddr == REG_IRQ_MASK)
            irqMask <= pwdata[IRQ_W-1:0];
    end

    // Set wins over a write-one clear in the same cycle.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            irqStat <= '0;
        else if (busWrite && paddr == REG_IRQ_STAT)
            irqStat <= (irqStat & ~pwdata[IRQ_W-1:0]) | irqEvent;
        else
            irqStat <= irqStat | irqEvent;
    end

    assign irq = |(irqStat & irqMask);

    always_comb
    begin
        prdata = 32'h0;
        unique case (paddr)
            REG_CTRL: prdata = {30'h0, ctrl};
            REG_STATUS: prdata = {24'h0, supplyLow, !extReset_n, outputsForceLow, resetLed,
                                  watchdogLed, supervision_relay, mode};
            REG_IRQ_STAT: prdata = {28'h0, irqStat};
            REG_IRQ_MASK: prdata = {28'h0, irqMask};
            REG_TIMER: prdata = wdCount;
            default: prdata = 32'h0;
        endcase
    end

    // ------------------------------------------------------------
    // External reset filter
    // ------------------------------------------------------------
    logic [31:0] extCount;
    logic extActive;

    // Reset is declared once the grounded input has stood for the filter time.
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            extCount <= '0;
        else if (extReset_n)
            extCount <= '0;
        else if (extCount < EXTRST_CYC - EXT_RST_SYNC_CYC)
            extCount <= extCount + 32'h1;
    end

    assign extActive = !extReset_n && (extCount >= EXTRST_CYC - EXT_RST_SYNC_CYC);
    assign inReset = extActive || supplyLow;

    // ------------------------------------------------------------
    // Operating mode
    // ------------------------------------------------------------
    logic haltEff;
    logic clearEff;
    logic clearPrev;

    assign haltEff = switch_enable_jumper && haltSwitch;
    assign clearEff = switch_enable_jumper && clearSwitch;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            mode <= WDRS_RESET;
        else if (inReset)
            mode <= WDRS_RESET;
        else if (haltEff)
            mode <= WDRS_HALT;
        else if (ctrl[CTRL_RUN_BIT])
            mode <= WDRS_RUN;
        else
            mode <= WDRS_STOP;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            clearPrev <= 1'b0;
        else
            clearPrev <= clearEff;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            ctlPulse <= '{default: 1'b1};
        else
        begin
            ctlPulse.clearOutputs <= inReset;
            ctlPulse.clearTimers <= inReset;
            ctlPulse.zeroIp <= inReset;
            ctlPulse.clearElements <= clearEff && !clearPrev;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            resetLed <= 1'b1;
        else
            resetLed <= inReset;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            outputsForceLow <= 1'b1;
        else
            outputsForceLow <= inReset
                || (outputs_low_jumper && (mode == WDRS_HALT || mode == WDRS_STOP));
    end

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    logic wdHit;
    logic wdLevel;
    logic wdToggle;
    logic wdRun;
    logic relayPrev;

    assign wdHit = ioWrite && (ioAddr == WD_ADDR_LO || ioAddr == WD_ADDR_HI);
    assign wdToggle = wdHit && (ioData != wdLevel);
    assign wdRun = (mode == WDRS_RUN) && ctrl[CTRL_WDEN_BIT];

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            wdLevel <= 1'b0;
        else if (wdHit)
            wdLevel <= ioData;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || !wdRun)
            wdCount <= '0;
        else if (wdToggle)
            wdCount <= '0;
        else if (wdCount < TIMEOUT_CYC)
            wdCount <= wdCount + 32'h1;
    end

    assign wdExpired = (wdCount >= TIMEOUT_CYC);

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            supervision_relay <= 1'b0;
        else if (!wdRun || wdExpired)
            supervision_relay <= 1'b0;
        else if (wdToggle)
            supervision_relay <= 1'b1;
    end

    assign watchdogLed = supervision_relay;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            relayPrev <= 1'b0;
        else
            relayPrev <= supervision_relay;
    end

    logic extPrev;
    logic lowPrev;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            extPrev <= 1'b0;
            lowPrev <= 1'b0;
        end
        else
        begin
            extPrev <= extActive;
            lowPrev <= supplyLow;
        end
    end

    always_comb
    begin
        irqEvent = '0;
        irqEvent[IRQ_TIMEOUT_BIT] = relayPrev && !supervision_relay;
        irqEvent[IRQ_EXTRST_BIT] = extActive && !extPrev;
        irqEvent[IRQ_LOWV_BIT] = supplyLow && !lowPrev;
        // Taken from the press itself: the clear pulse register idles high in reset.
        irqEvent[IRQ_CLEAR_BIT] = clearEff && !clearPrev;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_relay_needs_run: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (mode != WDRS_RUN) |=> !supervision_relay)
        else $error("relay energised outside RUN");

    a_relay_timeout_drop: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wdExpired |=> !supervision_relay)
        else $error("relay held after timeout");

    a_led_follows_relay: assert property (@(posedge sys_clk) disable iff (sys_rst)
        watchdogLed == supervision_relay)
        else $error("watchdog led mismatch");

    a_relay_rises_toggle: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(supervision_relay) |-> $past(wdToggle))
        else $error("relay energised without toggle");

    a_timeout_bound: assert property (@(posedge sys_clk) disable iff (sys_rst)
        wdCount <= TIMEOUT_CYC)
        else $error("watchdog counter overran");

    a_lowv_reset: assert property (@(posedge sys_clk) disable iff (sys_rst)
        supplyLow |=> (mode == WDRS_RESET) && resetLed)
        else $error("low voltage did not reset");

    a_ext_reset_clears: assert property (@(posedge sys_clk) disable iff (sys_rst)
        extActive |=> ctlPulse.clearOutputs && ctlPulse.clearTimers && ctlPulse.zeroIp
            && outputsForceLow)
        else $error("external reset did not clear");

    a_ext_reset_time: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (extCount >= EXTRST_CYC - EXT_RST_SYNC_CYC) && !extReset_n |=> resetLed)
        else $error("external reset too slow");

    a_switch_gated: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !switch_enable_jumper |=> !ctlPulse.clearElements)
        else $error("clear acted without jumper");

    a_halt_switch: assert property (@(posedge sys_clk) disable iff (sys_rst)
        haltEff && !inReset |=> mode == WDRS_HALT)
        else $error("halt switch ignored");

    a_outputs_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
        outputs_low_jumper && (mode == WDRS_HALT || mode == WDRS_STOP) |=> outputsForceLow)
        else $error("outputs not forced low");

endmodule : wdrs_supervisor

//--- verif/wdrs_proc_model.sv
module wdrs_proc_model
    import wdrs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic toggleOn,
    input wire logic useHi,
    output logic ioWrite,
    output logic [8:0] ioAddr,
    output logic ioData
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------
    // Cyclic program, one watchdog complement every 20 cycles.
    // ----------
    logic [4:0] cnt = 5'h00;
    logic level = 1'h0;
    initial ioWrite = 1'h0;
    initial ioAddr = 9'h000;
    initial ioData = 1'h0;
    always @(posedge sys_clk)
    begin
        cnt <= (cnt == 5'h13) ? 5'h00 : cnt + 5'h01;
        if (cnt == 5'h00 && toggleOn)
        begin
            level <= ~level;
            ioWrite <= 1'h1;
            ioAddr <= useHi ? WD_ADDR_HI : WD_ADDR_LO;
            ioData <= ~level;
        end
        else if (cnt == 5'h09)
        begin
            ioWrite <= 1'h1;
            ioAddr <= 9'h0A0;
            ioData <= ~ioData;
        end
        else
        begin
            ioWrite <= 1'h0;
            ioAddr <= ~ioAddr;
            ioData <= ~ioData;
        end
    end
endmodule : wdrs_proc_model

//--- verif/wdrs_supervisor_tb.sv
module wdrs_supervisor_tb
    import wdrs_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TO = 50;
    localparam int XR = 10;
    logic sys_clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, ioWrite, ioData, err, irq, supervision_relay, watchdogLed, resetLed, outputsForceLow;
    logic [8:0] ioAddr;
    logic extReset_n = 1'h1, supplyLow = 1'h0, haltSwitch = 1'h0, clearSwitch = 1'h0;
    logic switch_enable_jumper = 1'h0, outputs_low_jumper = 1'h0, toggleOn = 1'h0, useHi = 1'h0;
    wdrs_ctl_s ctlPulse;
    wdrs_mode_e mode;
    int errorCnt = 0, nCompared = 0, cycles = 0, clrCnt = 0;

    wdrs_supervisor #(.TIMEOUT_CYC(TO), .EXTRST_CYC(XR)) wdrs_supervisor_inst (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ioWrite(ioWrite), .ioAddr(ioAddr), .ioData(ioData), .extReset_n(extReset_n),
        .supplyLow(supplyLow), .haltSwitch(haltSwitch), .clearSwitch(clearSwitch),
        .switch_enable_jumper(switch_enable_jumper), .outputs_low_jumper(outputs_low_jumper),
        .supervision_relay(supervision_relay), .watchdogLed(watchdogLed), .resetLed(resetLed),
        .outputsForceLow(outputsForceLow), .ctlPulse(ctlPulse), .mode(mode), .irq(irq));
    wdrs_proc_model wdrs_proc_model_inst (.sys_clk(sys_clk), .toggleOn(toggleOn), .useHi(useHi),
        .ioWrite(ioWrite), .ioAddr(ioAddr), .ioData(ioData));

    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (ctlPulse.clearElements === 1'h1)
            clrCnt++;
        if (cycles == 20000)
        begin
            errorCnt++;
            testDone();
        end
    end
    // ----------
    // Helpers
    // ----------
    task automatic testDone();
        if (errorCnt == 0 && nCompared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : testDone
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
    endtask : cyc
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge sys_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'h1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'h1 && n < 50);
        rdat = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (n >= 50)
            errorCnt++;
    endtask : apb
    // ----------
    // Scenarios
    // ----------
    task automatic tReset();
        check("resetLed", resetLed, 1'h1);
        check("relay", supervision_relay, 1'h0);
        sys_rst <= 1'h0;
        cyc(3);
        check("mode", mode, WDRS_STOP);
        check("resetLed", resetLed, 1'h0);
        apb(1'h1, 8'h14, 32'h1);
        check("slverr", err, 1'h1);
        apb(1'h0, 8'h14, 32'h0);
        check("rdata", rdat, 32'h0);
        apb(1'h0, REG_IRQ_STAT, 32'h0);
        check("irqStat", rdat, 32'h0);
        apb(1'h1, REG_IRQ_STAT, 32'hF);
        apb(1'h1, REG_IRQ_MASK, 32'hF);
    endtask : tReset
    task automatic tWatchdog();
        toggleOn <= 1'h1;
        apb(1'h1, REG_CTRL, 32'h3);
        cyc(45);
        check("relay", supervision_relay, 1'h1);
        useHi <= 1'h1;
        cyc(3 * TO);
        check("relay", supervision_relay, 1'h1);
        apb(1'h0, REG_STATUS, 32'h0);
        check("status", rdat, 32'h0C);
        toggleOn <= 1'h0;
        cyc(TO + 25);
        check("relay", supervision_relay, 1'h0);
        check("led", watchdogLed, 1'h0);
        apb(1'h0, REG_TIMER, 32'h0);
        check("timer", rdat, TO);
        check("irq", irq, 1'h1);
        apb(1'h1, REG_IRQ_MASK, 32'h0);
        cyc(1);
        check("irq", irq, 1'h0);
        apb(1'h1, REG_IRQ_MASK, 32'hF);
        apb(1'h1, REG_IRQ_STAT, 32'h1);
        cyc(1);
        check("irq", irq, 1'h0);
    endtask : tWatchdog
    task automatic tLeaveRun();
        toggleOn <= 1'h1;
        cyc(45);
        check("led", watchdogLed, 1'h1);
        apb(1'h1, REG_CTRL, 32'h2);
        cyc(3);
        check("mode", mode, WDRS_STOP);
        check("relay", supervision_relay, 1'h0);
        outputs_low_jumper <= 1'h1;
        cyc(3);
        check("forceLow", outputsForceLow, 1'h1);
        outputs_low_jumper <= 1'h0;
        cyc(3);
        check("forceLow", outputsForceLow, 1'h0);
        apb(1'h1, REG_CTRL, 32'h3);
        cyc(45);
        check("relay", supervision_relay, 1'h1);
        apb(1'h1, REG_CTRL, 32'h1);
        cyc(3);
        check("relay", supervision_relay, 1'h0);
        apb(1'h1, REG_CTRL, 32'h3);
        cyc(45);
    endtask : tLeaveRun
    task automatic tResets();
        extReset_n <= 1'h0;
        cyc(XR + 1);
        check("mode", mode, WDRS_RESET);
        check("resetLed", resetLed, 1'h1);
        check("ctl", ctlPulse[3:1], 3'h7);
        cyc(2);
        check("relay", supervision_relay, 1'h0);
        extReset_n <= 1'h1;
        cyc(3);
        check("mode", mode, WDRS_RUN);
        supplyLow <= 1'h1;
        cyc(3);
        check("mode", mode, WDRS_RESET);
        supplyLow <= 1'h0;
        cyc(3);
        check("resetLed", resetLed, 1'h0);
        apb(1'h0, REG_IRQ_STAT, 32'h0);
        check("irqResets", rdat[2:1], 2'h3);
        apb(1'h1, REG_IRQ_STAT, 32'hF);
    endtask : tResets
    task automatic tSwitches();
        clrCnt = 0;
        haltSwitch <= 1'h1;
        clearSwitch <= 1'h1;
        cyc(4);
        check("mode", mode, WDRS_RUN);
        check("clears", clrCnt, 0);
        haltSwitch <= 1'h0;
        clearSwitch <= 1'h0;
        switch_enable_jumper <= 1'h1;
        outputs_low_jumper <= 1'h1;
        cyc(2);
        clearSwitch <= 1'h1;
        cyc(5);
        check("clears", clrCnt, 1);
        check("irq", irq, 1'h1);
        apb(1'h0, REG_CTRL, 32'h0);
        check("ctrl", rdat, 32'h3);
        haltSwitch <= 1'h1;
        cyc(3);
        check("mode", mode, WDRS_HALT);
        check("forceLow", outputsForceLow, 1'h1);
    endtask : tSwitches

    initial
    begin
        cyc(16);
        tReset();
        tWatchdog();
        tLeaveRun();
        tResets();
        tSwitches();
        testDone();
    end
endmodule : wdrs_supervisor_tb
